// File: rtl/rft1_pkg.sv
// Constants, field layout and event carrier for the second reader timer.
// Assumes a byte-addressed 32-bit register bus, one register per word.
// Contract
// - With halt_on_first_rx_bits set, the count stops once the first 4 bits of a card reply arrive.
// - In either oscillator trimming mode halt_on_first_rx_bits has no effect.
// - auto_start_select 00b never starts the timer; 01b starts it when an RF transmission ends.
// - auto_start_select 10b and 11b trim the low_freq_oscillator, start and stop on its rising edge, 11b with underflow.
// - With reload_on_zero set, reaching zero reloads the reload word and counting goes on, except under auto_start_select 10b, where the timer stops at zero.
// - With reload_on_zero clear, the timer counts to zero, stops and holds.
// - Every underflow sets second_timer_underflow_flag, restart or not.
// - tick_source_select 00b counts 13.56 MHz ticks and 01b counts 211.875 kHz ticks from the carrier.
// - tick_source_select 10b counts first timer underflows and 11b third timer underflows.
// - Every start event loads the counter from the high and low reload bytes.
// - Writing a reload byte leaves a running count alone until the next start or the next reload at zero.
// - The current count reads back as a high and a low read-only byte.
// - The first timer count low byte reads back at index 13h.
// - A write to shared_timer_run_control changes second_timer_active only with its write enable set.
package rft1_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_T0_CNT_LO = 8'h13;
    localparam logic [7:0] IDX_SETUP = 8'h14;
    localparam logic [7:0] IDX_RLD_HI = 8'h15;
    localparam logic [7:0] IDX_RLD_LO = 8'h16;
    localparam logic [7:0] IDX_CNT_HI = 8'h17;
    localparam logic [7:0] IDX_CNT_LO = 8'h18;
    localparam logic [7:0] IDX_RUN_CTRL = 8'h0f;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

    // Setup register fields
    localparam int SETUP_HALT_BIT = 7;
    localparam int SETUP_AUTO_LSB = 4;
    localparam int SETUP_RESTART_BIT = 3;
    localparam int SETUP_TICK_LSB = 0;
    localparam logic [7:0] SETUP_MASK = 8'hbb;
    localparam logic [7:0] SETUP_RESET = 8'h00;

    // Shared run control fields
    localparam int RUN_ACTIVE_BIT = 5;
    localparam int RUN_WE_BIT = 1;

    // Interrupt fields
    localparam int IRQ_UF_BIT = 0;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;

    // auto_start_select codes
    localparam logic [1:0] AUTO_NONE = 2'b00;
    localparam logic [1:0] AUTO_TX_END = 2'b01;
    localparam logic [1:0] AUTO_TRIM = 2'b10;
    localparam logic [1:0] AUTO_TRIM_UF = 2'b11;

    // tick_source_select codes
    localparam logic [1:0] TICK_CARRIER = 2'b00;
    localparam logic [1:0] TICK_SLOW = 2'b01;
    localparam logic [1:0] TICK_FIRST = 2'b10;
    localparam logic [1:0] TICK_THIRD = 2'b11;

    // Slow tick is the carrier tick divided down
    localparam int CARRIER_HZ = 13_560_000;
    localparam int SLOW_HZ = 211_875;
    localparam int SLOW_DIV = CARRIER_HZ / SLOW_HZ;

    typedef enum logic {ST_IDLE, ST_COUNT} rft1_state_e;

    // Single-cycle event pulses from neighbouring logic
    typedef struct packed {
        logic tx_end;
        logic rx_first_bits;
        logic lfo_edge;
        logic carrier_tick;
        logic first_uf;
        logic third_uf;
    } rft1_evt_s;

endpackage

// File: rtl/rft1_timer.sv
// Second general reader timer with its Avalon-MM register slave.
// Assumes all event pulses are one ref_clk cycle wide and synchronous.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module rft1_timer #(
    parameter int CNT_W = 16,
    parameter int DIV_W = 6
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire rft1_pkg::rft1_evt_s evt,
    input wire logic [7:0] first_count_low,
    output logic underflow_pulse,
    output logic irq
);
    import rft1_pkg::*;

    rft1_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [7:0] setup;
    logic [7:0] reload_hi;
    logic [7:0] reload_lo;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [DIV_W-1:0] div_cnt;
    logic slow_tick;

    // Bus decode
    logic req;
    logic wr;
    logic [7:0] idx;
    logic lane0;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    assign req = avs_read | avs_write;
    assign wr = avs_write & ~avs_waitrequest;
    assign idx = avs_address[9:2];
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    // Setup fields
    logic halt_en;
    logic [1:0] auto_sel;
    logic restart;
    logic [1:0] tick_sel;
    logic trim;
    logic [CNT_W-1:0] reload_word;

    assign halt_en = setup[SETUP_HALT_BIT];
    assign auto_sel = setup[SETUP_AUTO_LSB +: 2];
    assign restart = setup[SETUP_RESTART_BIT];
    assign tick_sel = setup[SETUP_TICK_LSB +: 2];
    assign trim = auto_sel[1];
    assign reload_word = CNT_W'({reload_hi, reload_lo});

    // Events that steer the counter
    logic active;
    logic sw_hit;
    logic sw_start;
    logic sw_stop;
    logic tx_start;
    logic lfo_start;
    logic lfo_stop;
    logic rx_halt;
    logic any_start;
    logic any_stop;
    logic tick;
    logic at_end;
    logic uf_allowed;
    logic next_uf;

    assign active = (state == ST_COUNT);
    // A register write moves the running bit only under its write enable
    assign sw_hit = wr & lane0 & (idx == IDX_RUN_CTRL)
        & wbyte[RUN_WE_BIT];
    assign sw_start = sw_hit & wbyte[RUN_ACTIVE_BIT];
    assign sw_stop = sw_hit & ~wbyte[RUN_ACTIVE_BIT];
    assign tx_start = (auto_sel == AUTO_TX_END) & evt.tx_end
        & ~active;
    assign lfo_start = trim & evt.lfo_edge & ~active;
    assign lfo_stop = trim & evt.lfo_edge & active;
    // Trimming masks the receive halt
    assign rx_halt = ~trim & halt_en & evt.rx_first_bits
        & active;
    assign any_start = sw_start | tx_start | lfo_start;
    assign any_stop = sw_stop | lfo_stop | rx_halt;

    // Tick source selection
    always_comb begin
        case (tick_sel)
            TICK_CARRIER: tick = evt.carrier_tick;
            TICK_SLOW: tick = slow_tick;
            TICK_FIRST: tick = evt.first_uf;
            TICK_THIRD: tick = evt.third_uf;
            default: tick = 1'b0;
        endcase
    end

    // A count of zero on start also ends at the first tick
    assign at_end = (cnt <= CNT_W'(1));
    assign uf_allowed = (auto_sel != AUTO_TRIM);
    assign next_uf = active & tick & at_end & ~any_stop
        & ~sw_start & uf_allowed;

    // Carrier divider for the slow tick; free running keeps phase
    // independent of starts, at most one slow period of jitter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= '0;
            slow_tick <= 1'b0;
        end else if (evt.carrier_tick) begin
            if (div_cnt == DIV_W'(SLOW_DIV - 1)) begin
                div_cnt <= '0;
                slow_tick <= 1'b1;
            end else begin
                div_cnt <= div_cnt + DIV_W'(1);
                slow_tick <= 1'b0;
            end
        end else begin
            slow_tick <= 1'b0;
        end
    end

    // Run state and counter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else if (sw_stop) begin
            state <= ST_IDLE;
        end else if (any_start) begin
            state <= ST_COUNT;
            cnt <= reload_word;
        end else if (any_stop) begin
            state <= ST_IDLE;
        end else if (active && tick) begin
            case (state)
                ST_COUNT: begin
                    if (!at_end) begin
                        cnt <= cnt - CNT_W'(1);
                    end else if (restart && uf_allowed) begin
                        cnt <= reload_word;
                    end else begin
                        cnt <= '0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Underflow pulse for cascading into sibling timers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            underflow_pulse <= 1'b0;
        end else begin
            underflow_pulse <= next_uf;
        end
    end

    // Setup and reload registers; reload writes never touch cnt
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            setup <= SETUP_RESET;
            reload_hi <= RELOAD_RESET;
            reload_lo <= RELOAD_RESET;
        end else if (wr && lane0) begin
            case (idx)
                IDX_SETUP: setup <= wbyte & SETUP_MASK;
                IDX_RLD_HI: reload_hi <= wbyte;
                IDX_RLD_LO: reload_lo <= wbyte;
                default: setup <= setup;
            endcase
        end
    end

    // Sticky status, set wins over write-one-to-clear
    logic stat_clr;
    assign stat_clr = wr & lane0 & (idx == IDX_IRQ_STAT)
        & wbyte[IRQ_UF_BIT];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= IRQ_RESET;
        end else if (next_uf) begin
            irq_stat[IRQ_UF_BIT] <= 1'b1;
        end else if (stat_clr) begin
            irq_stat[IRQ_UF_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask <= IRQ_RESET;
        end else if (wr && lane0 && idx == IDX_IRQ_MASK) begin
            irq_mask[IRQ_UF_BIT] <= wbyte[IRQ_UF_BIT];
        end
    end

    // One cycle behind the status bit, kept registered
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Read mux; counter bytes are live, so a read mid-count may
    // pair halves from different ticks
    always_comb begin
        case (idx)
            IDX_T0_CNT_LO: rd_byte = first_count_low;
            IDX_SETUP: rd_byte = setup;
            IDX_RLD_HI: rd_byte = reload_hi;
            IDX_RLD_LO: rd_byte = reload_lo;
            IDX_CNT_HI: rd_byte = cnt[15:8];
            IDX_CNT_LO: rd_byte = cnt[7:0];
            IDX_RUN_CTRL: rd_byte = 8'(active) << RUN_ACTIVE_BIT;
            IDX_IRQ_STAT: rd_byte = irq_stat;
            IDX_IRQ_MASK: rd_byte = irq_mask;
            default: rd_byte = 8'h00;
        endcase
    end

    // One wait cycle on every access, then a one-cycle answer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // Helper: no start, stop or halt in this cycle
    logic quiet;
    assign quiet = ~any_start & ~any_stop;

    a_halt_on_rx:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (rx_halt && !sw_start) |=> !active)
    else $error("receive halt did not stop the count");

    a_trim_no_halt:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (trim && active && evt.rx_first_bits && !evt.lfo_edge
        && !sw_hit && !(tick && at_end)) |=> active)
    else $error("receive halt acted during trimming");

    a_no_auto_start:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (auto_sel == AUTO_NONE && !active && !sw_start)
        |=> !active)
    else $error("timer started by itself");

    a_tx_end_start:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (auto_sel == AUTO_TX_END && evt.tx_end && !active
        && !sw_stop) |=> active ##0 cnt == $past(reload_word))
    else $error("transmission end did not start timer");

    a_lfo_toggle:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (trim && evt.lfo_edge && !sw_hit)
        |=> active != $past(active))
    else $error("oscillator edge did not toggle run");

    a_restart_reload:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (active && tick && at_end && restart && quiet
        && auto_sel != AUTO_TRIM)
        |=> active && cnt == $past(reload_word))
    else $error("auto restart did not reload");

    a_stop_at_zero:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (active && tick && at_end && !restart && quiet)
        |=> (!active && cnt == '0) [*2])
    else $error("count did not stop and hold at zero");

    a_flag_on_uf:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        underflow_pulse |-> irq_stat[IRQ_UF_BIT])
    else $error("underflow left the flag clear");

    a_slow_spacing:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        slow_tick |=> !slow_tick)
    else $error("slow tick wider than one cycle");

    a_first_uf_tick:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick_sel == TICK_FIRST && evt.first_uf && active
        && !at_end && quiet) |=> cnt == $past(cnt) - CNT_W'(1))
    else $error("first timer underflow did not count");

    a_start_loads:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (sw_start && !sw_stop)
        |=> active && cnt == $past(reload_word))
    else $error("start did not load reload word");

    a_reload_no_disturb:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr && (idx == IDX_RLD_HI || idx == IDX_RLD_LO)
        && active && !tick && quiet)
        |=> cnt == $past(cnt))
    else $error("reload write changed the count");

    a_count_read:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (avs_read && avs_waitrequest && idx == IDX_CNT_LO)
        |=> avs_readdata[7:0] == $past(cnt[7:0]))
    else $error("count low byte read back wrong");

    a_run_needs_we:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (!sw_hit && !tx_start && !lfo_start && !active)
        |=> !active)
    else $error("run bit changed without enable");

    a_decrement:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (active && tick && !at_end && quiet)
        |=> cnt == $past(cnt) - CNT_W'(1) && !underflow_pulse)
    else $error("count did not step down by one");

    a_rx_no_halt:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (!halt_en && active && evt.rx_first_bits && !sw_hit
        && !evt.lfo_edge && !(tick && at_end)) |=> active)
    else $error("receive stopped timer with halt clear");

    a_trim_no_uf:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (auto_sel == AUTO_TRIM) |=> !underflow_pulse)
    else $error("underflow in trimming without underflow");

    a_idle_hold:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (!active && !any_start) |=> cnt == $past(cnt))
    else $error("idle count changed");

    a_flag_sticky:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (irq_stat[IRQ_UF_BIT] && !stat_clr) |=> irq_stat[IRQ_UF_BIT])
    else $error("underflow flag cleared without a write");

    a_irq_level:
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (irq_stat[IRQ_UF_BIT] && irq_mask[IRQ_UF_BIT]) |=> irq)
    else $error("unmasked flag did not raise irq");

endmodule // rft1_timer

// File: sim/rft1_timer_tb.sv
// Self-checking bench for the second reader timer and its register slave.
// Assumes the register indices and field codes of rft1_pkg.
`timescale 1ns/1ps

module rft1_timer_tb;
    import rft1_pkg::*;

    // Event bit positions inside the packed carrier
    localparam int E_TX = 5;
    localparam int E_RX = 4;
    localparam int E_LFO = 3;
    localparam int E_TICK = 2;
    localparam int E_FIRST = 1;
    localparam int E_THIRD = 0;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    rft1_evt_s evt = '0;
    logic [7:0] first_count_low = 8'ha5;
    logic underflow_pulse;
    logic irq;
    logic uf;
    int miscompares = 0;
    int cmp_count = 0;

    rft1_timer u_dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .evt(evt),
        .first_count_low(first_count_low),
        .underflow_pulse(underflow_pulse),
        .irq(irq)
    );

    always #25 ref_clk = ~ref_clk;

    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            give_verdict();
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        check({8'h00, q}, {8'h00, exp});
    endtask

    task automatic cnt_is(input logic [15:0] exp);
        logic [7:0] hi;
        logic [7:0] lo;
        // Only called once any card reply has ended
        bus(1'b0, IDX_CNT_HI, 8'h00, hi);
        bus(1'b0, IDX_CNT_LO, 8'h00, lo);
        check({hi, lo}, exp);
    endtask

    task automatic active_is(input logic exp);
        logic [7:0] q;
        bus(1'b0, IDX_RUN_CTRL, 8'h00, q);
        check({15'h0, q[RUN_ACTIVE_BIT]}, {15'h0, exp});
    endtask

    // One-cycle event pulse; underflow sampled after the taking edge
    task automatic pulse(input int k, output logic u);
        logic [5:0] v;
        v = '0;
        v[k] = 1'b1;
        @(posedge ref_clk);
        evt <= rft1_evt_s'(v);
        @(posedge ref_clk);
        evt <= '0;
        #1 u = underflow_pulse;
    endtask

    task automatic arm(input logic [15:0] rld, input logic [7:0] setup);
        wr(IDX_RUN_CTRL, 8'h02);
        wr(IDX_RLD_HI, rld[15:8]);
        wr(IDX_RLD_LO, rld[7:0]);
        wr(IDX_SETUP, setup);
    endtask

    task automatic sc_regs();
        chk_reg(IDX_SETUP, SETUP_RESET);
        chk_reg(IDX_RLD_LO, RELOAD_RESET);
        chk_reg(IDX_IRQ_STAT, IRQ_RESET);
        cnt_is(16'h0000);
        chk_reg(IDX_T0_CNT_LO, 8'ha5);
        first_count_low <= 8'h3c;
        chk_reg(IDX_T0_CNT_LO, 8'h3c);
        wr(8'h3f, 8'h5a);
        chk_reg(8'h3f, 8'h00);
        wr(IDX_SETUP, 8'hff);
        chk_reg(IDX_SETUP, SETUP_MASK);
        wr(IDX_RUN_CTRL, 8'h20);
        active_is(1'b0);
    endtask

    task automatic sc_oneshot();
        arm(16'h0003, 8'h00);
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_RUN_CTRL, 8'h22);
        cnt_is(16'h0003);
        pulse(E_TICK, uf);
        cnt_is(16'h0002);
        pulse(E_TICK, uf);
        pulse(E_TICK, uf);
        check({15'h0, uf}, 16'h0001);
        pulse(E_TICK, uf);
        check({15'h0, uf}, 16'h0000);
        cnt_is(16'h0000);
        active_is(1'b0);
        chk_reg(IDX_IRQ_STAT, 8'h01);
        check({15'h0, irq}, 16'h0000);
        wr(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1 check({15'h0, irq}, 16'h0001);
        wr(IDX_IRQ_STAT, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1 check({15'h0, irq}, 16'h0000);
    endtask

    task automatic sc_restart();
        arm(16'h0002, 8'h08);
        wr(IDX_RUN_CTRL, 8'h22);
        wr(IDX_RLD_LO, 8'h05);
        cnt_is(16'h0002);
        pulse(E_TICK, uf);
        cnt_is(16'h0001);
        pulse(E_TICK, uf);
        check({15'h0, uf}, 16'h0001);
        active_is(1'b1);
        pulse(E_TICK, uf);
        check({15'h0, uf}, 16'h0000);
        chk_reg(IDX_IRQ_STAT, 8'h01);
        wr(IDX_IRQ_STAT, 8'h01);
    endtask

    task automatic sc_sources();
        arm(16'h0100, 8'h01);
        wr(IDX_RUN_CTRL, 8'h22);
        repeat (2 * SLOW_DIV) pulse(E_TICK, uf);
        cnt_is(16'h00fe);
        arm(16'h0005, 8'h02);
        wr(IDX_RUN_CTRL, 8'h22);
        pulse(E_TICK, uf);
        pulse(E_THIRD, uf);
        cnt_is(16'h0005);
        pulse(E_FIRST, uf);
        cnt_is(16'h0004);
        arm(16'h0005, 8'h03);
        wr(IDX_RUN_CTRL, 8'h22);
        pulse(E_FIRST, uf);
        pulse(E_THIRD, uf);
        cnt_is(16'h0004);
    endtask

    task automatic sc_autostart();
        arm(16'h0007, 8'h00);
        pulse(E_TX, uf);
        active_is(1'b0);
        wr(IDX_SETUP, 8'h90);
        pulse(E_TX, uf);
        active_is(1'b1);
        cnt_is(16'h0007);
        pulse(E_TICK, uf);
        pulse(E_RX, uf);
        active_is(1'b0);
        pulse(E_TICK, uf);
        cnt_is(16'h0006);
        arm(16'h0007, 8'h10);
        pulse(E_TX, uf);
        pulse(E_RX, uf);
        active_is(1'b1);
    endtask

    task automatic sc_trim();
        arm(16'h0001, 8'hb0);
        pulse(E_LFO, uf);
        active_is(1'b1);
        pulse(E_RX, uf);
        active_is(1'b1);
        pulse(E_LFO, uf);
        active_is(1'b0);
        pulse(E_LFO, uf);
        pulse(E_TICK, uf);
        check({15'h0, uf}, 16'h0001);
        chk_reg(IDX_IRQ_STAT, 8'h01);
        arm(16'h0001, 8'h20);
        wr(IDX_IRQ_STAT, 8'h01);
        pulse(E_LFO, uf);
        pulse(E_TICK, uf);
        check({15'h0, uf}, 16'h0000);
        cnt_is(16'h0000);
        chk_reg(IDX_IRQ_STAT, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        sc_regs();
        sc_oneshot();
        sc_restart();
        sc_sources();
        sc_autostart();
        sc_trim();
        give_verdict();
    end
endmodule // rft1_timer_tb
